// ==== pin_mux_pkg.sv ====
// constants shared by the port pin function multiplexer
package pin_mux_pkg;
	// pin configuration field codes
	localparam logic [3:0] CFG_ANALOG      = 4'h0;
	localparam logic [3:0] CFG_GPIO_OUT    = 4'h1;
	localparam logic [3:0] CFG_GPIO_IN     = 4'h4;
	localparam logic [3:0] CFG_GPIO_OD     = 4'h5;
	localparam logic [3:0] CFG_ALT_OUT     = 4'h9;
	localparam logic [3:0] CFG_ALT_OD      = 4'hd;
	localparam int         CFG_FIELD_W     = 4;

	// field positions inside the pin configuration words
	localparam int PD2_CFG_LSB  = 8;
	localparam int PD3_CFG_LSB  = 12;
	localparam int PB3_CFG_LSB  = 12;
	localparam int PB4_CFG_LSB  = 0;
	localparam int PA0_CFG_LSB  = 0;
	localparam int CFG_WORD_W   = 16;

	// serial controller function select codes
	localparam logic [1:0] SER_OFF  = 2'h0;
	localparam logic [1:0] SER_UART = 2'h1;
	localparam logic [1:0] SER_SPI  = 2'h2;
	localparam logic [1:0] SER_TWI  = 2'h3;

	// control bit positions
	localparam int SPI_MASTER_BIT = 4;
	localparam int UART_FLOW_BIT  = 5;
	localparam int REMAP_CH1_BIT  = 4;
	localparam int REMAP_CH3_BIT  = 6;
	localparam int REMAP_CH4_BIT  = 7;
	localparam int CH1_OE_BIT     = 0;
	localparam int CH3_OE_BIT     = 2;
	localparam int CH4_OE_BIT     = 3;

	// global pin numbering, port * 8 + pin
	localparam int NUM_PINS   = 32;
	localparam int IDX_PA0    = 0;
	localparam int IDX_PB3    = 11;
	localparam int IDX_PB4    = 12;
	localparam int IDX_PD2    = 26;
	localparam int IDX_PD3    = 27;
	localparam int PIN_SEL_W  = 5;
	localparam int SYNC_DEPTH = 2;

	// reset values
	localparam logic [4:0] PAD_OUT_RST = 5'h00;
	localparam logic [4:0] PAD_OE_RST  = 5'h00;
endpackage

// ==== level_sync.sv ====
// two-stage pad synchroniser
`timescale 1ns/10ps
module level_sync #(
	parameter int WIDTH = 1
) (
	input  wire logic             clk_sys,
	input  wire logic             rst,
	input  wire logic [WIDTH-1:0] async_in,
	output logic      [WIDTH-1:0] sync_out
);
	logic [WIDTH-1:0] meta_r;

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			meta_r   <= '0;
			sync_out <= '0;
		end else begin
			meta_r   <= async_in;
			sync_out <= meta_r;
		end
	end
endmodule

// ==== pin_function_mux.sv ====
// pin function multiplexer for five shared port pins
`timescale 1ns/10ps

// What this block does
// R01: d two: spi3 data in
// R02: d two: open-drain twi clock
// R03: d two: uart3 receive
// R04: d three: cts3 with flow
// R05: d three: spi3 clock
// R06: b three: timer ch3 out
// R07: b three: spi1 master clock
// R08: b three: cts1 with flow
// R09: b three: spi1 slave clock in
// R10: b four: timer ch4 out
// R11: b four: rts1 when unclaimed
// R12: b four: spi1 slave select in
// R13: a zero: timer ch1 out
// R14: a zero: spi2 master data
// R15: a zero: spi2 slave data in
// R16: analog a zero goes to usb
// R17: timer inputs follow remap
// R18: interrupts select any pin
// R19: otherwise plain gpio
module pin_function_mux (
	input  wire logic                                clk_sys,
	input  wire logic                                rst,
	// pads: d two, d three, b three, b four, a zero
	input  wire logic [4:0]                          pad_in,
	output logic      [4:0]                          pad_out,
	output logic      [4:0]                          pad_oe,
	input  wire logic [pin_mux_pkg::NUM_PINS-1:0]    other_pad_in,
	// gpio output data and input read-back
	input  wire logic [4:0]                          gpio_out_data,
	output logic      [4:0]                          gpio_in_data,
	// configuration
	input  wire logic [pin_mux_pkg::CFG_WORD_W-1:0]  port_d_low_pin_config,
	input  wire logic [pin_mux_pkg::CFG_WORD_W-1:0]  port_b_low_pin_config,
	input  wire logic [pin_mux_pkg::CFG_WORD_W-1:0]  port_b_high_pin_config,
	input  wire logic [pin_mux_pkg::CFG_WORD_W-1:0]  port_a_low_pin_config,
	input  wire logic [7:0]                          timer_two_remap_option,
	input  wire logic [3:0]                          timer_two_channel_output_enable,
	input  wire logic [1:0]                          serial1_function_select,
	input  wire logic [1:0]                          serial2_function_select,
	input  wire logic [1:0]                          serial3_function_select,
	input  wire logic [7:0]                          serial1_spi_config,
	input  wire logic [7:0]                          serial2_spi_config,
	input  wire logic [7:0]                          serial3_spi_config,
	input  wire logic [7:0]                          serial1_uart_config,
	input  wire logic [7:0]                          serial3_uart_config,
	input  wire logic                                usb_present,
	// outputs placed on pads
	input  wire logic                                serial3_twi_clock_out,
	input  wire logic                                serial3_spi_clock_out,
	input  wire logic                                serial1_spi_clock_out,
	input  wire logic                                serial1_request_to_send_n,
	input  wire logic                                serial2_spi_master_out,
	input  wire logic                                timer_two_channel_one_out,
	input  wire logic                                timer_two_channel_three_out,
	input  wire logic                                timer_two_channel_four_out,
	// timer inputs from other remap pins, synchronised
	input  wire logic                                timer_two_channel_one_alt_in,
	input  wire logic                                timer_two_channel_three_alt_in,
	input  wire logic                                timer_two_channel_four_alt_in,
	// controller inputs
	output logic                                     serial3_spi_master_in,
	output logic                                     serial3_spi_slave_in,
	output logic                                     serial3_twi_clock_in,
	output logic                                     serial3_uart_receive,
	output logic                                     serial3_clear_to_send_n,
	output logic                                     serial3_spi_clock_in,
	output logic                                     serial1_clear_to_send_n,
	output logic                                     serial1_spi_clock_in,
	output logic                                     serial1_slave_select_n,
	output logic                                     serial2_spi_slave_in,
	output logic                                     timer_two_channel_one_in,
	output logic                                     timer_two_channel_three_in,
	output logic                                     timer_two_channel_four_in,
	output logic                                     usb_minus_line_select,
	// selectable interrupts
	input  wire logic [pin_mux_pkg::PIN_SEL_W-1:0]   interrupt_c_pin_select,
	input  wire logic [pin_mux_pkg::PIN_SEL_W-1:0]   interrupt_d_pin_select,
	output logic                                     selectable_interrupt_c,
	output logic                                     selectable_interrupt_d
);
	import pin_mux_pkg::*;

	localparam int P_D2 = 0;
	localparam int P_D3 = 1;
	localparam int P_B3 = 2;
	localparam int P_B4 = 3;
	localparam int P_A0 = 4;

	function automatic logic [3:0] cfg_field(input logic [CFG_WORD_W-1:0] word, input int lsb);
		cfg_field = word[lsb +: CFG_FIELD_W];
	endfunction

	function automatic logic is_alt(input logic [3:0] cfg);
		is_alt = (cfg == CFG_ALT_OUT) || (cfg == CFG_ALT_OD);
	endfunction

	logic [NUM_PINS-1:0] all_pad_raw;
	logic [NUM_PINS-1:0] all_pad_sync;
	logic [3:0]          cfg_d2;
	logic [3:0]          cfg_d3;
	logic [3:0]          cfg_b3;
	logic [3:0]          cfg_b4;
	logic [3:0]          cfg_a0;
	logic [4:0]          pin_lvl;
	logic                s1_spi;
	logic                s1_uart;
	logic                s2_spi;
	logic                s3_spi;
	logic                s3_uart;
	logic                s3_twi;
	logic                s1_master;
	logic                s2_master;
	logic                s3_master;
	logic                s1_flow;
	logic                s3_flow;
	logic                ch1_claim;
	logic                ch3_claim;
	logic                ch4_claim;
	logic [4:0]          pad_out_nxt;
	logic [4:0]          pad_oe_nxt;

	// all pads pass two flops
	always_comb begin
		all_pad_raw          = other_pad_in;
		all_pad_raw[IDX_PD2] = pad_in[P_D2];
		all_pad_raw[IDX_PD3] = pad_in[P_D3];
		all_pad_raw[IDX_PB3] = pad_in[P_B3];
		all_pad_raw[IDX_PB4] = pad_in[P_B4];
		all_pad_raw[IDX_PA0] = pad_in[P_A0];
	end

	level_sync #(
		.WIDTH    (NUM_PINS)
	) u_sync (
		.clk_sys  (clk_sys),
		.rst      (rst),
		.async_in (all_pad_raw),
		.sync_out (all_pad_sync)
	);

	assign pin_lvl = {all_pad_sync[IDX_PA0], all_pad_sync[IDX_PB4], all_pad_sync[IDX_PB3],
			all_pad_sync[IDX_PD3], all_pad_sync[IDX_PD2]};

	assign cfg_d2 = cfg_field(port_d_low_pin_config, PD2_CFG_LSB);
	assign cfg_d3 = cfg_field(port_d_low_pin_config, PD3_CFG_LSB);
	assign cfg_b3 = cfg_field(port_b_low_pin_config, PB3_CFG_LSB);
	assign cfg_b4 = cfg_field(port_b_high_pin_config, PB4_CFG_LSB);
	assign cfg_a0 = cfg_field(port_a_low_pin_config, PA0_CFG_LSB);

	assign s1_spi    = serial1_function_select == SER_SPI;
	assign s1_uart   = serial1_function_select == SER_UART;
	assign s2_spi    = serial2_function_select == SER_SPI;
	assign s3_spi    = serial3_function_select == SER_SPI;
	assign s3_uart   = serial3_function_select == SER_UART;
	assign s3_twi    = serial3_function_select == SER_TWI;
	assign s1_master = serial1_spi_config[SPI_MASTER_BIT];
	assign s2_master = serial2_spi_config[SPI_MASTER_BIT];
	assign s3_master = serial3_spi_config[SPI_MASTER_BIT];
	assign s1_flow   = serial1_uart_config[UART_FLOW_BIT];
	assign s3_flow   = serial3_uart_config[UART_FLOW_BIT];

	// timer claims on the shared pins
	assign ch1_claim = !timer_two_remap_option[REMAP_CH1_BIT]
			&& timer_two_channel_output_enable[CH1_OE_BIT]; // R13
	assign ch3_claim = timer_two_remap_option[REMAP_CH3_BIT]
			&& timer_two_channel_output_enable[CH3_OE_BIT]; // R06
	assign ch4_claim = timer_two_remap_option[REMAP_CH4_BIT]
			&& timer_two_channel_output_enable[CH4_OE_BIT]; // R10

	// pad drive selection
	always_comb begin
		pad_out_nxt = gpio_out_data;
		pad_oe_nxt  = '0;

		// port_d_pin_two
		if (s3_twi && cfg_d2 == CFG_ALT_OD) begin
			pad_out_nxt[P_D2] = 1'b0; // R02
			pad_oe_nxt[P_D2]  = !serial3_twi_clock_out; // R02
		end else if (cfg_d2 == CFG_GPIO_OUT) begin
			pad_oe_nxt[P_D2]  = 1'b1; // R19
		end else if (cfg_d2 == CFG_GPIO_OD) begin
			pad_out_nxt[P_D2] = 1'b0; // R19
			pad_oe_nxt[P_D2]  = !gpio_out_data[P_D2]; // R19
		end

		// port_d_pin_three
		if (s3_spi && s3_master && cfg_d3 == CFG_ALT_OUT) begin
			pad_out_nxt[P_D3] = serial3_spi_clock_out; // R05
			pad_oe_nxt[P_D3]  = 1'b1; // R05
		end else if (cfg_d3 == CFG_GPIO_OUT) begin
			pad_oe_nxt[P_D3]  = 1'b1; // R19
		end else if (cfg_d3 == CFG_GPIO_OD) begin
			pad_out_nxt[P_D3] = 1'b0; // R19
			pad_oe_nxt[P_D3]  = !gpio_out_data[P_D3]; // R19
		end

		// port_b_pin_three
		if (ch3_claim && cfg_b3 == CFG_ALT_OUT) begin
			pad_out_nxt[P_B3] = timer_two_channel_three_out; // R06
			pad_oe_nxt[P_B3]  = 1'b1; // R06
		end else if (!ch3_claim && s1_spi && s1_master && cfg_b3 == CFG_ALT_OUT) begin
			pad_out_nxt[P_B3] = serial1_spi_clock_out; // R07
			pad_oe_nxt[P_B3]  = 1'b1; // R07
		end else if (cfg_b3 == CFG_GPIO_OUT) begin
			pad_oe_nxt[P_B3]  = 1'b1; // R19
		end else if (cfg_b3 == CFG_GPIO_OD) begin
			pad_out_nxt[P_B3] = 1'b0; // R19
			pad_oe_nxt[P_B3]  = !gpio_out_data[P_B3]; // R19
		end

		// port_b_pin_four
		if (ch4_claim && cfg_b4 == CFG_ALT_OUT) begin
			pad_out_nxt[P_B4] = timer_two_channel_four_out; // R10
			pad_oe_nxt[P_B4]  = 1'b1; // R10
		end else if (!ch4_claim && s1_uart && s1_flow && cfg_b4 == CFG_ALT_OUT) begin
			pad_out_nxt[P_B4] = serial1_request_to_send_n; // R11
			pad_oe_nxt[P_B4]  = 1'b1; // R11
		end else if (cfg_b4 == CFG_GPIO_OUT) begin
			pad_oe_nxt[P_B4]  = 1'b1; // R19
		end else if (cfg_b4 == CFG_GPIO_OD) begin
			pad_out_nxt[P_B4] = 1'b0; // R19
			pad_oe_nxt[P_B4]  = !gpio_out_data[P_B4]; // R19
		end

		// port_a_pin_zero
		if (usb_present && cfg_a0 == CFG_ANALOG) begin
			pad_out_nxt[P_A0] = 1'b0; // R16
			pad_oe_nxt[P_A0]  = 1'b0; // R16
		end else if (ch1_claim && cfg_a0 == CFG_ALT_OUT) begin
			pad_out_nxt[P_A0] = timer_two_channel_one_out; // R13
			pad_oe_nxt[P_A0]  = 1'b1; // R13
		end else if (!ch1_claim && s2_spi && s2_master && cfg_a0 == CFG_ALT_OUT) begin
			pad_out_nxt[P_A0] = serial2_spi_master_out; // R14
			pad_oe_nxt[P_A0]  = 1'b1; // R14
		end else if (cfg_a0 == CFG_GPIO_OUT) begin
			pad_oe_nxt[P_A0]  = 1'b1; // R19
		end else if (cfg_a0 == CFG_GPIO_OD) begin
			pad_out_nxt[P_A0] = 1'b0; // R19
			pad_oe_nxt[P_A0]  = !gpio_out_data[P_A0]; // R19
		end
	end

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			pad_out <= PAD_OUT_RST;
			pad_oe  <= PAD_OE_RST;
		end else begin
			pad_out <= pad_out_nxt;
			pad_oe  <= pad_oe_nxt;
		end
	end

	// usb hand-over
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			usb_minus_line_select <= 1'b0;
		end else begin
			usb_minus_line_select <= usb_present && cfg_a0 == CFG_ANALOG; // R16
		end
	end

	// serial controller 3 inputs
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			serial3_spi_master_in   <= 1'b0;
			serial3_spi_slave_in    <= 1'b0;
			serial3_twi_clock_in    <= 1'b1;
			serial3_uart_receive    <= 1'b1;
			serial3_clear_to_send_n <= 1'b1;
			serial3_spi_clock_in    <= 1'b0;
		end else begin
			serial3_spi_master_in   <= s3_spi && s3_master && pin_lvl[P_D2]; // R01
			serial3_spi_slave_in    <= s3_spi && !s3_master && pin_lvl[P_D2]; // R01
			serial3_twi_clock_in    <= !s3_twi || pin_lvl[P_D2]; // R02
			serial3_uart_receive    <= !s3_uart || pin_lvl[P_D2]; // R03
			serial3_clear_to_send_n <= !(s3_uart && s3_flow) || pin_lvl[P_D3]; // R04
			serial3_spi_clock_in    <= s3_spi && !s3_master && pin_lvl[P_D3]; // R05
		end
	end

	// serial controller 1 and 2 inputs
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			serial1_clear_to_send_n <= 1'b1;
			serial1_spi_clock_in    <= 1'b0;
			serial1_slave_select_n  <= 1'b1;
			serial2_spi_slave_in    <= 1'b0;
		end else begin
			serial1_clear_to_send_n <= !(s1_uart && s1_flow) || pin_lvl[P_B3]; // R08
			serial1_spi_clock_in    <= s1_spi && !s1_master && pin_lvl[P_B3]; // R09
			serial1_slave_select_n  <= !(s1_spi && !s1_master) || pin_lvl[P_B4]; // R12
			serial2_spi_slave_in    <= s2_spi && !s2_master && pin_lvl[P_A0]; // R15
		end
	end

	// timer inputs follow the remap bits
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			timer_two_channel_one_in   <= 1'b0;
			timer_two_channel_three_in <= 1'b0;
			timer_two_channel_four_in  <= 1'b0;
		end else begin
			timer_two_channel_one_in   <= timer_two_remap_option[REMAP_CH1_BIT]
					? timer_two_channel_one_alt_in : pin_lvl[P_A0];
			timer_two_channel_three_in <= timer_two_remap_option[REMAP_CH3_BIT]
					? pin_lvl[P_B3] : timer_two_channel_three_alt_in; // R17
			timer_two_channel_four_in  <= timer_two_remap_option[REMAP_CH4_BIT]
					? pin_lvl[P_B4] : timer_two_channel_four_alt_in; // R17
		end
	end

	// gpio read-back and interrupt routing
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			gpio_in_data           <= '0;
			selectable_interrupt_c <= 1'b0;
			selectable_interrupt_d <= 1'b0;
		end else begin
			gpio_in_data           <= pin_lvl; // R19
			selectable_interrupt_c <= all_pad_sync[interrupt_c_pin_select]; // R18
			selectable_interrupt_d <= all_pad_sync[interrupt_d_pin_select]; // R18
		end
	end
endmodule

// ==== pad_model.sv ====
// board-side pad model
`timescale 1ns/10ps
module pad_model (
	input  wire logic [4:0] pad_out,
	input  wire logic [4:0] pad_oe,
	input  wire logic [4:0] ext_lvl,
	output logic      [4:0] pad_in
);
	// board level wins while the pin is released
	assign pad_in = (pad_oe & pad_out) | (~pad_oe & ext_lvl);
endmodule

// ==== pin_function_mux_chk.sv ====
// port checker for the pin function multiplexer
`timescale 1ns/10ps
module pin_function_mux_chk
	import pin_mux_pkg::*;
(
	input wire logic        clk_sys,
	input wire logic        rst,
	input wire logic [4:0]  pad_in,
	input logic      [4:0]  pad_out,
	input logic      [4:0]  pad_oe,
	input wire logic [15:0] port_d_low_pin_config,
	input wire logic [15:0] port_b_low_pin_config,
	input wire logic [15:0] port_b_high_pin_config,
	input wire logic [15:0] port_a_low_pin_config,
	input wire logic [7:0]  timer_two_remap_option,
	input wire logic [3:0]  timer_two_channel_output_enable,
	input wire logic [1:0]  serial1_function_select,
	input wire logic [1:0]  serial2_function_select,
	input wire logic [1:0]  serial3_function_select,
	input wire logic [7:0]  serial1_spi_config,
	input wire logic [7:0]  serial2_spi_config,
	input wire logic [7:0]  serial3_spi_config,
	input wire logic [7:0]  serial1_uart_config,
	input wire logic [7:0]  serial3_uart_config,
	input wire logic        usb_present,
	input wire logic        serial3_twi_clock_out,
	input wire logic        serial3_spi_clock_out,
	input wire logic        serial1_spi_clock_out,
	input wire logic        serial1_request_to_send_n,
	input wire logic        serial2_spi_master_out,
	input wire logic        timer_two_channel_one_out,
	input wire logic        timer_two_channel_three_out,
	input wire logic        timer_two_channel_four_out,
	input logic             serial3_uart_receive,
	input logic             serial3_clear_to_send_n,
	input logic             usb_minus_line_select
);
	logic       t1;
	logic       t3;
	logic       t4;
	logic [2:0] up_r;
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (rst);
	assign t1 = !timer_two_remap_option[REMAP_CH1_BIT] && timer_two_channel_output_enable[CH1_OE_BIT];
	assign t3 = timer_two_remap_option[REMAP_CH3_BIT] && timer_two_channel_output_enable[CH3_OE_BIT];
	assign t4 = timer_two_remap_option[REMAP_CH4_BIT] && timer_two_channel_output_enable[CH4_OE_BIT];
	// cycles since reset, stops counting at 4
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) up_r <= 3'h0;
		else if (up_r != 3'h4) up_r <= up_r + 3'h1;
	end
	sequence uart3_held;
		(up_r == 3'h4 && serial3_function_select == SER_UART)[*4];
	endsequence
	AST_TIMER3_OUT: assert property (t3 && port_b_low_pin_config[15:12] == CFG_ALT_OUT
		|=> pad_oe[2] && pad_out[2] == $past(timer_two_channel_three_out)) else $error("timer ch3 not on pad");
	AST_SPI1_CLK_OUT: assert property (!t3 && serial1_function_select == SER_SPI && serial1_spi_config[4]
		&& port_b_low_pin_config[15:12] == CFG_ALT_OUT |=> pad_oe[2] && pad_out[2] == $past(serial1_spi_clock_out))
		else $error("spi1 clock not on pad");
	AST_TIMER4_OUT: assert property (t4 && port_b_high_pin_config[3:0] == CFG_ALT_OUT
		|=> pad_oe[3] && pad_out[3] == $past(timer_two_channel_four_out)) else $error("timer ch4 not on pad");
	AST_RTS1_OUT: assert property (!t4 && serial1_function_select == SER_UART && serial1_uart_config[5]
		&& port_b_high_pin_config[3:0] == CFG_ALT_OUT |=> pad_oe[3] && pad_out[3] == $past(serial1_request_to_send_n))
		else $error("rts not on pad");
	AST_TIMER1_OUT: assert property (t1 && port_a_low_pin_config[3:0] == CFG_ALT_OUT
		|=> pad_oe[4] && pad_out[4] == $past(timer_two_channel_one_out)) else $error("timer ch1 not on pad");
	AST_SPI2_DATA_OUT: assert property (!t1 && serial2_function_select == SER_SPI && serial2_spi_config[4]
		&& port_a_low_pin_config[3:0] == CFG_ALT_OUT |=> pad_oe[4] && pad_out[4] == $past(serial2_spi_master_out))
		else $error("spi2 data not on pad");
	AST_TWI_OPEN_DRAIN: assert property (serial3_function_select == SER_TWI
		&& port_d_low_pin_config[11:8] == CFG_ALT_OD |=> !pad_out[0] && pad_oe[0] == !$past(serial3_twi_clock_out))
		else $error("twi clock not open drain");
	AST_SPI3_CLK_OUT: assert property (serial3_function_select == SER_SPI && serial3_spi_config[4]
		&& port_d_low_pin_config[15:12] == CFG_ALT_OUT |=> pad_oe[1] && pad_out[1] == $past(serial3_spi_clock_out))
		else $error("spi3 clock not on pad");
	AST_USB_ANALOG: assert property (port_a_low_pin_config[3:0] == CFG_ANALOG && usb_present
		|=> usb_minus_line_select && !pad_oe[4]) else $error("usb select missing");
	AST_UART3_RX: assert property (uart3_held |-> serial3_uart_receive == $past(pad_in[0], 3))
		else $error("uart receive not from pad");
	AST_CTS3_IDLE: assert property (!(serial3_function_select == SER_UART && serial3_uart_config[5])
		|=> serial3_clear_to_send_n) else $error("cts3 routed without flow control");
endmodule

// ==== tb_pin_function_mux.sv ====
// testbench for the pin function multiplexer
`timescale 1ns/10ps
module tb_pin_function_mux;
	import pin_mux_pkg::*;
	logic clk_sys, rst, usb_present, serial3_twi_clock_out, serial3_spi_clock_out, serial1_spi_clock_out;
	logic serial1_request_to_send_n, serial2_spi_master_out, timer_two_channel_one_out;
	logic timer_two_channel_three_out, timer_two_channel_four_out, timer_two_channel_one_alt_in;
	logic timer_two_channel_three_alt_in, timer_two_channel_four_alt_in;
	logic serial3_spi_master_in, serial3_spi_slave_in, serial3_twi_clock_in, serial3_uart_receive;
	logic serial3_clear_to_send_n, serial3_spi_clock_in, serial1_clear_to_send_n, serial1_spi_clock_in;
	logic serial1_slave_select_n, serial2_spi_slave_in, timer_two_channel_one_in, timer_two_channel_three_in;
	logic timer_two_channel_four_in, usb_minus_line_select, selectable_interrupt_c, selectable_interrupt_d;
	logic [4:0]  pad_in, pad_out, pad_oe, gpio_out_data, gpio_in_data, ext_lvl, interrupt_c_pin_select;
	logic [4:0]  interrupt_d_pin_select;
	logic [31:0] other_pad_in;
	logic [15:0] port_d_low_pin_config, port_b_low_pin_config, port_b_high_pin_config, port_a_low_pin_config;
	logic [7:0]  timer_two_remap_option, serial1_spi_config, serial2_spi_config, serial3_spi_config;
	logic [7:0]  serial1_uart_config, serial3_uart_config;
	logic [3:0]  timer_two_channel_output_enable;
	logic [1:0]  serial1_function_select, serial2_function_select, serial3_function_select;
	int          bad_count;
	int          tests_run;

	pin_function_mux dut_u (.*);
	pad_model pm_u (.*);

	task automatic results;
		$display("checks %0d mismatches %0d", tests_run, bad_count);
		if (bad_count == 0 && tests_run > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [4:0] e, input logic [4:0] g);
		tests_run++;
		if (g !== e) begin
			bad_count++;
			$display("wrong value %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic wt(input int n);
		repeat (n) @(negedge clk_sys);
	endtask

	task automatic t_port_d;
		serial3_function_select = SER_SPI; serial3_spi_config = 8'h10;
		port_d_low_pin_config[15:12] = CFG_ALT_OUT; serial3_spi_clock_out = 1'b1; ext_lvl[0] = 1'b1;
		wt(4);
		chk("spi3 clk pad", 5'h3, {pad_oe[1], pad_out[1]});
		chk("spi3 master in", 5'h2, {serial3_spi_master_in, serial3_spi_slave_in});
		serial3_spi_config = 8'h00; ext_lvl[1] = 1'b1;
		wt(4);
		chk("spi3 slave clk", 5'h1, {pad_oe[1], serial3_spi_clock_in});
		chk("spi3 slave in", 5'h1, {serial3_spi_master_in, serial3_spi_slave_in});
		serial3_function_select = SER_UART; ext_lvl[1:0] = 2'h0; serial3_uart_config = 8'h00;
		wt(4);
		chk("uart3 rx", 5'h0, serial3_uart_receive);
		chk("cts3 no flow", 5'h1, serial3_clear_to_send_n);
		serial3_uart_config = 8'h20;
		wt(4);
		chk("cts3 flow", 5'h0, serial3_clear_to_send_n);
		serial3_function_select = SER_TWI; port_d_low_pin_config[11:8] = CFG_ALT_OD; serial3_twi_clock_out = 1'b0;
		wt(2);
		chk("twi pull low", 5'h2, {pad_oe[0], pad_out[0]});
		serial3_twi_clock_out = 1'b1; ext_lvl[0] = 1'b1;
		wt(4);
		chk("twi release", 5'h1, {pad_oe[0], serial3_twi_clock_in});
		ext_lvl[0] = 1'b0;
		wt(4);
		chk("twi clk in", 5'h0, serial3_twi_clock_in);
		$display("done port d");
	endtask

	task automatic t_port_b;
		port_b_low_pin_config[15:12] = CFG_ALT_OUT; serial1_function_select = SER_SPI; serial1_spi_config = 8'h10;
		timer_two_remap_option = 8'h40; timer_two_channel_output_enable = 4'h4;
		timer_two_channel_three_out = 1'b1; serial1_spi_clock_out = 1'b0;
		wt(2);
		chk("timer3 pad", 5'h3, {pad_oe[2], pad_out[2]});
		timer_two_channel_output_enable = 4'h0;
		wt(2);
		chk("spi1 clk pad", 5'h2, {pad_oe[2], pad_out[2]});
		timer_two_channel_output_enable = 4'h4; timer_two_remap_option = 8'h00;
		timer_two_channel_three_out = 1'b0; serial1_spi_clock_out = 1'b1;
		wt(2);
		chk("spi1 clk unmapped", 5'h3, {pad_oe[2], pad_out[2]});
		timer_two_channel_output_enable = 4'h0; serial1_spi_config = 8'h00; ext_lvl[2] = 1'b1;
		wt(4);
		chk("timer3 alt in", 5'h0, timer_two_channel_three_in);
		chk("spi1 slave clk", 5'h1, serial1_spi_clock_in);
		timer_two_remap_option = 8'h40;
		wt(2);
		chk("timer3 pad in", 5'h1, timer_two_channel_three_in);
		serial1_function_select = SER_UART; serial1_uart_config = 8'h20; ext_lvl[2] = 1'b0;
		wt(4);
		chk("cts1 flow", 5'h0, serial1_clear_to_send_n);
		serial1_uart_config = 8'h00;
		wt(2);
		chk("cts1 no flow", 5'h1, serial1_clear_to_send_n);
		port_b_high_pin_config[3:0] = CFG_ALT_OUT; serial1_uart_config = 8'h20; timer_two_remap_option = 8'h80;
		timer_two_channel_output_enable = 4'h8; timer_two_channel_four_out = 1'b1; serial1_request_to_send_n = 1'b0;
		wt(2);
		chk("timer4 pad", 5'h3, {pad_oe[3], pad_out[3]});
		timer_two_remap_option = 8'h00;
		wt(2);
		chk("rts1 pad", 5'h2, {pad_oe[3], pad_out[3]});
		timer_two_channel_output_enable = 4'h0; timer_two_remap_option = 8'h80; timer_two_channel_four_alt_in = 1'b1;
		serial1_function_select = SER_SPI; serial1_spi_config = 8'h00; ext_lvl[3] = 1'b0;
		wt(4);
		chk("ssel1 in", 5'h0, serial1_slave_select_n);
		chk("timer4 pad in", 5'h0, timer_two_channel_four_in);
		$display("done port b");
	endtask

	task automatic t_port_a;
		port_a_low_pin_config[3:0] = CFG_ALT_OUT; timer_two_remap_option = 8'h00; timer_two_channel_output_enable = 4'h1;
		timer_two_channel_one_out = 1'b1; serial2_function_select = SER_SPI; serial2_spi_config = 8'h10;
		serial2_spi_master_out = 1'b0;
		wt(2);
		chk("timer1 pad", 5'h3, {pad_oe[4], pad_out[4]});
		timer_two_remap_option = 8'h10;
		wt(2);
		chk("spi2 data pad", 5'h2, {pad_oe[4], pad_out[4]});
		serial2_spi_config = 8'h00; timer_two_channel_output_enable = 4'h0; ext_lvl[4] = 1'b1;
		wt(4);
		chk("spi2 slave in", 5'h1, serial2_spi_slave_in);
		chk("timer1 alt in", 5'h0, timer_two_channel_one_in);
		port_a_low_pin_config[3:0] = CFG_ANALOG; usb_present = 1'b1;
		wt(2);
		chk("usb select", 5'h1, {pad_oe[4], usb_minus_line_select});
		usb_present = 1'b0;
		wt(2);
		chk("no usb part", 5'h0, usb_minus_line_select);
		$display("done port a");
	endtask

	task automatic t_gpio_irq;
		serial1_function_select = SER_OFF; serial2_function_select = SER_OFF; serial3_function_select = SER_OFF;
		port_d_low_pin_config = 16'h1111; port_b_low_pin_config = 16'h1111;
		port_b_high_pin_config = 16'h1111; port_a_low_pin_config = 16'h1111; gpio_out_data = 5'h15;
		other_pad_in = 32'h0000_0020; interrupt_c_pin_select = 5'h05; interrupt_d_pin_select = 5'(IDX_PB3);
		wt(4);
		chk("gpio drive", 5'h15, pad_out);
		chk("gpio enable", 5'h1f, pad_oe);
		chk("gpio in", 5'h15, gpio_in_data);
		chk("irq c other pin", 5'h1, selectable_interrupt_c);
		chk("irq d own pin", 5'h1, selectable_interrupt_d);
		interrupt_c_pin_select = 5'h06; interrupt_d_pin_select = 5'(IDX_PB4);
		wt(2);
		chk("irq reselect", 5'h0, {selectable_interrupt_c, selectable_interrupt_d});
		$display("done gpio irq");
	endtask

	initial begin
		clk_sys = 1'b0;
		forever #4 clk_sys = ~clk_sys;
	end
	initial begin
		#400000;
		bad_count++;
		results();
	end
	initial begin
		{rst, bad_count, tests_run} = {1'b1, 32'd0, 32'd0};
		{usb_present, serial3_twi_clock_out, serial3_spi_clock_out, serial1_spi_clock_out} = 4'h1;
		{serial1_request_to_send_n, serial2_spi_master_out, timer_two_channel_one_out} = 3'h4;
		{timer_two_channel_three_out, timer_two_channel_four_out, timer_two_channel_one_alt_in} = 3'h0;
		{timer_two_channel_three_alt_in, timer_two_channel_four_alt_in} = 2'h0;
		{other_pad_in, gpio_out_data, ext_lvl, interrupt_c_pin_select, interrupt_d_pin_select} = '0;
		{port_d_low_pin_config, port_b_low_pin_config, port_b_high_pin_config, port_a_low_pin_config} = {4{16'h4444}};
		{timer_two_remap_option, timer_two_channel_output_enable, serial1_uart_config, serial3_uart_config} = '0;
		{serial1_spi_config, serial2_spi_config, serial3_spi_config} = '0;
		{serial1_function_select, serial2_function_select, serial3_function_select} = '0;
		wt(4);
		chk("reset oe", 5'h0, pad_oe);
		chk("reset cts3", 5'h1, serial3_clear_to_send_n);
		rst = 1'b0;
		$display("done reset");
		t_port_d();
		t_port_b();
		t_port_a();
		t_gpio_irq();
		results();
	end
endmodule

bind pin_function_mux pin_function_mux_chk chk_u (.*);
